// ===== verilog/pmb_pkg.sv
// shared constants and types of the phy management parameter bank
package pmb_pkg;

  // ----------------------------------------------------------------
  // register byte offsets
  // ----------------------------------------------------------------
  localparam int AW = 7;
  localparam logic [AW-1:0] OFS_KIND = 7'h00;
  localparam logic [AW-1:0] OFS_REV = 7'h04;
  localparam logic [AW-1:0] OFS_LME_OPT = 7'h08;
  localparam logic [AW-1:0] OFS_CAP_CLAUSE = 7'h0C;
  localparam logic [AW-1:0] OFS_CAP_MODES = 7'h10;
  localparam logic [AW-1:0] OFS_CAP_RATES = 7'h14;
  localparam logic [AW-1:0] OFS_CAP_SEGS = 7'h18;
  localparam logic [AW-1:0] OFS_CAP_MISC = 7'h1C;
  localparam logic [AW-1:0] OFS_CAP_TXC = 7'h20;
  localparam logic [AW-1:0] OFS_CAP_RXC = 7'h24;
  localparam logic [AW-1:0] OFS_OP_MODE = 7'h28;
  localparam logic [AW-1:0] OFS_OP_RATE = 7'h2C;
  localparam logic [AW-1:0] OFS_OP_RXSEG = 7'h30;
  localparam logic [AW-1:0] OFS_OP_TXSEG = 7'h34;
  localparam logic [AW-1:0] OFS_OP_RXC = 7'h38;
  localparam logic [AW-1:0] OFS_OP_TXC = 7'h3C;
  localparam logic [AW-1:0] OFS_OP_REP = 7'h40;
  localparam logic [AW-1:0] OFS_BT_MODE = 7'h44;
  localparam logic [AW-1:0] OFS_BT_RATE = 7'h48;
  localparam logic [AW-1:0] OFS_BT_RXSEG = 7'h4C;
  localparam logic [AW-1:0] OFS_BT_TXSEG = 7'h50;
  localparam logic [AW-1:0] OFS_BT_RXC = 7'h54;
  localparam logic [AW-1:0] OFS_BT_TXC = 7'h58;
  localparam logic [AW-1:0] OFS_BT_REP = 7'h5C;
  localparam logic [AW-1:0] OFS_CTRL = 7'h60;
  localparam logic [AW-1:0] OFS_STATUS = 7'h64;

  // ----------------------------------------------------------------
  // fields, encodings, bus answers
  // ----------------------------------------------------------------
  localparam int CTRL_INIT_BIT = 0;
  localparam int ST_RO_ERR_BIT = 0;
  localparam int ST_CONS_ERR_BIT = 1;
  localparam logic [1:0] MODE_ORIG = 2'h1;
  localparam logic [1:0] MODE_REP = 2'h2;
  localparam logic [1:0] MODE_BOTH = 2'h3;
  localparam logic [1:0] SEG_CAP_TX = 2'h1;
  localparam logic [1:0] SEG_CAP_RX = 2'h2;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam logic [1:0] RESP_DECERR = 2'h3;
  localparam logic [31:0] LME_OPT_NONE = 32'h0;

  // ----------------------------------------------------------------
  // identity and capabilities of this build
  // ----------------------------------------------------------------
  // identity values are arbitrary
  localparam logic [31:0] ENTITY_KIND_ID = 32'h0000_0001;
  localparam logic [31:0] SPEC_REVISION_ID = 32'h0000_0001;
  localparam logic [31:0] CONFORMED_CLAUSE_ID = 32'h0000_0001;
  localparam logic [1:0] CAP_MODES = MODE_BOTH;
  // four rate codes, preferred first, zero marks an empty slot
  localparam logic [31:0] CAP_RATES = 32'h0000_0A05;
  localparam logic [7:0] TRUNK_IDENT = 8'h01;
  localparam logic [7:0] COPY_IDENT = 8'h02;
  localparam logic [1:0] TRUNK_CAP = 2'h3;
  localparam logic [1:0] COPY_CAP = 2'h3;
  localparam logic CAP_TX_LEVEL_ADJ = 1'b0;
  localparam logic CAP_RX_LEVEL_MEAS = 1'b1;
  // empty set means the carrier frequencies are unknown
  localparam logic [15:0] CAP_TX_CARRIERS = 16'h0000;
  localparam logic [15:0] CAP_RX_CARRIERS = 16'h0000;

  // ----------------------------------------------------------------
  // reset values of boot and operational parameters
  // ----------------------------------------------------------------
  localparam logic [1:0] RST_MODE = MODE_ORIG;
  localparam logic [7:0] RST_RATE = 8'h05;
  localparam logic [1:0] RST_SEGS = 2'h3;
  localparam logic [3:0] RST_CARRIER = 4'h0;
  localparam logic RST_REP_EN = 1'b0;

  typedef enum logic [4:0] {
    GRP_NONE = 5'b00000,
    GRP_ID = 5'b00001,
    GRP_CAP = 5'b00010,
    GRP_OPER = 5'b00100,
    GRP_BOOT = 5'b01000,
    GRP_CTRL = 5'b10000
  } pmb_grp_t;

endpackage : pmb_pkg

// ===== verilog/pmb_op_if.sv
// boot values, load strobe and operational values between bank and state
`timescale 1ns/1ps
`default_nettype none
interface pmb_op_if;
  logic [1:0] boot_mode;
  logic [7:0] boot_rate;
  logic [1:0] boot_rx_seg;
  logic [1:0] boot_tx_seg;
  logic [3:0] boot_rx_car;
  logic [3:0] boot_tx_car;
  logic boot_rep_en;
  logic load;
  logic [1:0] op_mode;
  logic [7:0] op_rate;
  logic [1:0] op_rx_seg;
  logic [1:0] op_tx_seg;
  logic [3:0] op_rx_car;
  logic [3:0] op_tx_car;
  logic op_rep_en;
  modport bank (output boot_mode, boot_rate, boot_rx_seg, boot_tx_seg,
    boot_rx_car, boot_tx_car, boot_rep_en, load,
    input op_mode, op_rate, op_rx_seg, op_tx_seg, op_rx_car, op_tx_car,
    op_rep_en);
  modport state (input boot_mode, boot_rate, boot_rx_seg, boot_tx_seg,
    boot_rx_car, boot_tx_car, boot_rep_en, load,
    output op_mode, op_rate, op_rx_seg, op_tx_seg, op_rx_car, op_tx_car,
    op_rep_en);
endinterface : pmb_op_if
`default_nettype wire

// ===== verilog/pmb_check.sv
// consistency check of a candidate boot value against the capabilities
`timescale 1ns/1ps
`default_nettype none
module pmb_check (
  input wire logic [pmb_pkg::AW-1:0] addr,
  input wire logic [31:0] value,
  output logic ok
);
  import pmb_pkg::*;

  logic [3:0] rate_hit;
  logic [1:0] seg_rx_cap;
  logic [1:0] seg_tx_cap;

  // R6: rate must be listed
  for (genvar i = 0; i < 4; i++) begin : g_rate
    assign rate_hit[i] = (value[7:0] != 8'h00) &&
      (value[7:0] == CAP_RATES[8*i +: 8]);
  end

  assign seg_rx_cap = {COPY_CAP[1], TRUNK_CAP[1]};
  assign seg_tx_cap = {COPY_CAP[0], TRUNK_CAP[0]};

  // R6: values inside capabilities
  always_comb begin
    ok = 1'b1;
    case (addr)
      OFS_BT_MODE: ok = (value[31:2] == 30'h0) &&
        ((value[1:0] == MODE_ORIG) || (value[1:0] == MODE_REP)) &&
        ((value[1:0] & CAP_MODES) == value[1:0]);
      OFS_BT_RATE: ok = (value[31:8] == 24'h0) && (|rate_hit);
      OFS_BT_RXSEG: ok = (value[31:2] == 30'h0) &&
        ((value[1:0] & ~seg_rx_cap) == 2'h0);
      OFS_BT_TXSEG: ok = (value[31:2] == 30'h0) &&
        ((value[1:0] & ~seg_tx_cap) == 2'h0);
      // R7: empty carrier set accepts any index
      OFS_BT_RXC: ok = (value[31:4] == 28'h0) &&
        ((CAP_RX_CARRIERS == 16'h0) || CAP_RX_CARRIERS[value[3:0]]);
      OFS_BT_TXC: ok = (value[31:4] == 28'h0) &&
        ((CAP_TX_CARRIERS == 16'h0) || CAP_TX_CARRIERS[value[3:0]]);
      OFS_BT_REP: ok = (value[31:1] == 31'h0) &&
        (!value[0] || CAP_RX_LEVEL_MEAS);
      default: ok = 1'b1;
    endcase
  end
endmodule : pmb_check
`default_nettype wire

// ===== verilog/pmb_opstate.sv
// operational state parameters, loaded from the boot values
`timescale 1ns/1ps
`default_nettype none
module pmb_opstate (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  pmb_op_if.state opi
);
  import pmb_pkg::*;

  // R5: all loaded in one step
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      opi.op_mode <= RST_MODE;
      opi.op_rate <= RST_RATE;
      opi.op_rx_seg <= RST_SEGS;
      opi.op_tx_seg <= RST_SEGS;
      opi.op_rx_car <= RST_CARRIER;
      opi.op_tx_car <= RST_CARRIER;
      opi.op_rep_en <= RST_REP_EN;
    end else if (ce && opi.load) begin
      opi.op_mode <= opi.boot_mode;
      opi.op_rate <= opi.boot_rate;
      opi.op_rx_seg <= opi.boot_rx_seg;
      opi.op_tx_seg <= opi.boot_tx_seg;
      opi.op_rx_car <= opi.boot_rx_car;
      opi.op_tx_car <= opi.boot_tx_car;
      opi.op_rep_en <= opi.boot_rep_en;
    end
  end
endmodule : pmb_opstate
`default_nettype wire

// ===== verilog/pmb_bank.sv
// management parameter bank of the phy entity, avalon-mm slave
//
// Function
// R1: option identification reads as none.
// R2: capability parameters are read-only; writes refused.
// R3: operational state is read-only from management.
// R4: boot parameters are readable and writable, one per operational value.
// R5: initialization copies every boot value into operational state at once.
// R6: boot and operational values stay inside advertised capabilities.
// R7: unknown carrier frequencies give an empty carrier set.
// R8: access level is decided per group only.
// R9: any subset of a group's parameters is serviced per request; the bank services one parameter word per access.
// R10: transmit-enabled segments are independent of actual transmission.
// R11: report-enable gates the off-normal received power peer report.
// R12: segment list gives trunk then redundant copy, each with capability.
// R13: supported modes encode originating, repeating, or both.
// R14: repeating mode blocks transmit onto the selected source segment.
// R15: writes to read-only parameters change nothing and answer error.
//
// Added by the designer: the Avalon-MM slave port and the address map.
`timescale 1ns/1ps
`default_nettype none
module pmb_bank (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic [pmb_pkg::AW-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic [1:0] avs_response,
  output logic avs_waitrequest,
  input wire logic init_req,
  input wire logic [1:0] rx_source_seg,
  input wire logic rx_off_normal,
  output logic [1:0] cur_mode,
  output logic [7:0] cur_rate,
  output logic [1:0] cur_rx_seg,
  output logic [1:0] cur_tx_seg_drive,
  output logic [3:0] cur_rx_carrier,
  output logic [3:0] cur_tx_carrier,
  output logic peer_report
);
  import pmb_pkg::*;

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  pmb_op_if opi();

  logic waitrequest_r;
  logic [31:0] readdata_r;
  logic [1:0] response_r;
  logic load_r;
  logic ro_err_r;
  logic cons_err_r;
  logic [1:0] tx_drive_r;
  logic peer_report_r;
  logic [1:0] boot_mode_r;
  logic [7:0] boot_rate_r;
  logic [1:0] boot_rx_seg_r;
  logic [1:0] boot_tx_seg_r;
  logic [3:0] boot_rx_car_r;
  logic [3:0] boot_tx_car_r;
  logic boot_rep_en_r;

  logic take;
  logic take_wr;
  logic take_rd;
  pmb_grp_t grp;
  logic [31:0] rd_val;
  logic [31:0] wmask;
  logic [31:0] merged;
  logic cand_ok;
  logic wr_boot;
  logic wr_ctrl;
  logic wr_ro;
  logic wr_refused;
  logic [1:0] src_block;

  // ----------------------------------------------------------------
  // group decode
  // ----------------------------------------------------------------
  // R8: one access level per group
  function automatic pmb_grp_t grp_of(input logic [AW-1:0] a);
    pmb_grp_t g;
    g = GRP_NONE;
    if (a[1:0] != 2'h0) begin
      g = GRP_NONE;
    end else if (a <= OFS_LME_OPT) begin
      g = GRP_ID;
    end else if (a <= OFS_CAP_RXC) begin
      g = GRP_CAP;
    end else if (a <= OFS_OP_REP) begin
      g = GRP_OPER;
    end else if (a <= OFS_BT_REP) begin
      g = GRP_BOOT;
    end else if (a <= OFS_STATUS) begin
      g = GRP_CTRL;
    end
    return g;
  endfunction : grp_of

  assign grp = grp_of(avs_address);

  // one wait cycle, then the answer for exactly one cycle
  assign take = (avs_read || avs_write) && waitrequest_r;
  assign take_wr = take && avs_write;
  assign take_rd = take && avs_read && !avs_write;

  // ----------------------------------------------------------------
  // read view
  // ----------------------------------------------------------------
  always_comb begin
    rd_val = 32'h0;
    case (avs_address)
      OFS_KIND: rd_val = ENTITY_KIND_ID;
      OFS_REV: rd_val = SPEC_REVISION_ID;
      // R1: option id is none
      OFS_LME_OPT: rd_val = LME_OPT_NONE;
      OFS_CAP_CLAUSE: rd_val = CONFORMED_CLAUSE_ID;
      // R13: orig, rep or both
      OFS_CAP_MODES: rd_val = {30'h0, CAP_MODES};
      OFS_CAP_RATES: rd_val = CAP_RATES;
      // R12: trunk first, copy second
      OFS_CAP_SEGS: rd_val = {12'h0, COPY_CAP, TRUNK_CAP,
        COPY_IDENT, TRUNK_IDENT};
      OFS_CAP_MISC: rd_val = {30'h0, CAP_RX_LEVEL_MEAS, CAP_TX_LEVEL_ADJ};
      // R7: empty set when unknown
      OFS_CAP_TXC: rd_val = {16'h0, CAP_TX_CARRIERS};
      OFS_CAP_RXC: rd_val = {16'h0, CAP_RX_CARRIERS};
      OFS_OP_MODE: rd_val = {30'h0, opi.op_mode};
      OFS_OP_RATE: rd_val = {24'h0, opi.op_rate};
      OFS_OP_RXSEG: rd_val = {30'h0, opi.op_rx_seg};
      // R10: enabled set, not activity
      OFS_OP_TXSEG: rd_val = {30'h0, opi.op_tx_seg};
      OFS_OP_RXC: rd_val = {28'h0, opi.op_rx_car};
      OFS_OP_TXC: rd_val = {28'h0, opi.op_tx_car};
      OFS_OP_REP: rd_val = {31'h0, opi.op_rep_en};
      OFS_BT_MODE: rd_val = {30'h0, boot_mode_r};
      OFS_BT_RATE: rd_val = {24'h0, boot_rate_r};
      OFS_BT_RXSEG: rd_val = {30'h0, boot_rx_seg_r};
      OFS_BT_TXSEG: rd_val = {30'h0, boot_tx_seg_r};
      OFS_BT_RXC: rd_val = {28'h0, boot_rx_car_r};
      OFS_BT_TXC: rd_val = {28'h0, boot_tx_car_r};
      OFS_BT_REP: rd_val = {31'h0, boot_rep_en_r};
      OFS_CTRL: rd_val = 32'h0;
      OFS_STATUS: rd_val = {30'h0, cons_err_r, ro_err_r};
      default: rd_val = 32'h0;
    endcase
  end

  // ----------------------------------------------------------------
  // write path
  // ----------------------------------------------------------------
  // byte lanes not enabled keep their stored bits
  assign wmask = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
    {8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
  assign merged = (rd_val & ~wmask) | (avs_writedata & wmask);

  pmb_check u_check (
    .addr(avs_address),
    .value(merged),
    .ok(cand_ok)
  );

  // R2: capability writes refused
  // R3: no write path to state
  // R15: read-only target answers error
  assign wr_ro = take_wr &&
    ((grp == GRP_ID) || (grp == GRP_CAP) || (grp == GRP_OPER));
  // R6: inconsistent boot value refused
  assign wr_refused = take_wr && (grp == GRP_BOOT) && !cand_ok;
  assign wr_boot = take_wr && (grp == GRP_BOOT) && cand_ok;
  assign wr_ctrl = take_wr && (grp == GRP_CTRL);

  // ----------------------------------------------------------------
  // bus answer
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      waitrequest_r <= 1'b1;
    end else if (ce) begin
      waitrequest_r <= !take;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      readdata_r <= 32'h0;
      response_r <= RESP_OKAY;
    end else if (ce && take) begin
      readdata_r <= take_rd ? rd_val : 32'h0;
      if (grp == GRP_NONE) begin
        response_r <= RESP_DECERR;
      end else if (wr_ro || wr_refused) begin
        response_r <= RESP_SLVERR;
      end else begin
        response_r <= RESP_OKAY;
      end
    end
  end

  // ----------------------------------------------------------------
  // boot parameters
  // ----------------------------------------------------------------
  // R4: boot values read-write
  // R9: each word serviced on its own
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      boot_mode_r <= RST_MODE;
      boot_rate_r <= RST_RATE;
      boot_rx_seg_r <= RST_SEGS;
      boot_tx_seg_r <= RST_SEGS;
      boot_rx_car_r <= RST_CARRIER;
      boot_tx_car_r <= RST_CARRIER;
      boot_rep_en_r <= RST_REP_EN;
    end else if (ce && wr_boot) begin
      case (avs_address)
        OFS_BT_MODE: boot_mode_r <= merged[1:0];
        OFS_BT_RATE: boot_rate_r <= merged[7:0];
        OFS_BT_RXSEG: boot_rx_seg_r <= merged[1:0];
        OFS_BT_TXSEG: boot_tx_seg_r <= merged[1:0];
        OFS_BT_RXC: boot_rx_car_r <= merged[3:0];
        OFS_BT_TXC: boot_tx_car_r <= merged[3:0];
        OFS_BT_REP: boot_rep_en_r <= merged[0];
        default: boot_rep_en_r <= boot_rep_en_r;
      endcase
    end
  end

  assign opi.boot_mode = boot_mode_r;
  assign opi.boot_rate = boot_rate_r;
  assign opi.boot_rx_seg = boot_rx_seg_r;
  assign opi.boot_tx_seg = boot_tx_seg_r;
  assign opi.boot_rx_car = boot_rx_car_r;
  assign opi.boot_tx_car = boot_tx_car_r;
  assign opi.boot_rep_en = boot_rep_en_r;
  assign opi.load = load_r;

  // ----------------------------------------------------------------
  // initialization and status
  // ----------------------------------------------------------------
  // R5: one-cycle load strobe
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      load_r <= 1'b0;
    end else if (ce) begin
      load_r <= init_req || (wr_ctrl && (avs_address == OFS_CTRL) &&
        avs_byteenable[0] && avs_writedata[CTRL_INIT_BIT]);
    end
  end

  // sticky flags, write one to clear; a new error wins over the clear
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ro_err_r <= 1'b0;
      cons_err_r <= 1'b0;
    end else if (ce) begin
      if (wr_ro) begin
        ro_err_r <= 1'b1;
      end else if (wr_ctrl && (avs_address == OFS_STATUS) &&
          avs_byteenable[0] && avs_writedata[ST_RO_ERR_BIT]) begin
        ro_err_r <= 1'b0;
      end
      if (wr_refused) begin
        cons_err_r <= 1'b1;
      end else if (wr_ctrl && (avs_address == OFS_STATUS) &&
          avs_byteenable[0] && avs_writedata[ST_CONS_ERR_BIT]) begin
        cons_err_r <= 1'b0;
      end
    end
  end

  pmb_opstate u_opstate (
    .clk(clk),
    .rst_n(rst_n),
    .ce(ce),
    .opi(opi)
  );

  // ----------------------------------------------------------------
  // link-side effects of the operational state
  // ----------------------------------------------------------------
  // R14: source segment not driven
  assign src_block = (opi.op_mode == MODE_REP) ? rx_source_seg : 2'h0;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tx_drive_r <= 2'h0;
    end else if (ce) begin
      tx_drive_r <= opi.op_tx_seg & ~src_block;
    end
  end

  // R11: report gated by enable
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      peer_report_r <= 1'b0;
    end else if (ce) begin
      peer_report_r <= rx_off_normal && opi.op_rep_en && CAP_RX_LEVEL_MEAS;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign avs_waitrequest = waitrequest_r;
  assign avs_readdata = readdata_r;
  assign avs_response = response_r;
  assign cur_mode = opi.op_mode;
  assign cur_rate = opi.op_rate;
  assign cur_rx_seg = opi.op_rx_seg;
  assign cur_tx_seg_drive = tx_drive_r;
  assign cur_rx_carrier = opi.op_rx_car;
  assign cur_tx_carrier = opi.op_tx_car;
  assign peer_report = peer_report_r;

endmodule : pmb_bank
`default_nettype wire

// ===== bench/pmb_bank_chk.sv
// assertions on the ports of the parameter bank
`timescale 1ns/1ps
`default_nettype none
module pmb_bank_chk (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic [pmb_pkg::AW-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [31:0] avs_readdata,
  input wire logic [1:0] avs_response,
  input wire logic avs_waitrequest,
  input wire logic init_req,
  input wire logic [1:0] rx_source_seg,
  input wire logic rx_off_normal,
  input wire logic [1:0] cur_mode,
  input wire logic [7:0] cur_rate,
  input wire logic [1:0] cur_rx_seg,
  input wire logic [1:0] cur_tx_seg_drive,
  input wire logic peer_report
);
  import pmb_pkg::*;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  logic tk;
  logic ld_r;
  assign tk = ce && avs_waitrequest && (avs_read || avs_write);
  // load request seen; held while gated, as the strobe is
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ld_r <= 1'b0;
    end else if (ce) begin
      ld_r <= init_req || (tk && avs_write && avs_address == OFS_CTRL
        && avs_writedata[CTRL_INIT_BIT]);
    end
  end
  chk_wait_one: assert property (tk |=> !avs_waitrequest)
    else $error("no answer one cycle after a taken request");
  chk_wait_pulse: assert property (ce && !avs_waitrequest |=> avs_waitrequest)
    else $error("answer cycle longer than one");
  chk_opt_none: assert property (tk && avs_read && avs_address == OFS_LME_OPT
    |=> avs_readdata == LME_OPT_NONE)
    else $error("option id not none");
  chk_ro_refuse: assert property (tk && avs_write && avs_address <= OFS_OP_REP
    && avs_address[1:0] == 2'h0 |=> avs_response == RESP_SLVERR)
    else $error("read-only write not refused");
  chk_seg_order: assert property (tk && avs_read && avs_address == OFS_CAP_SEGS
    |=> avs_readdata[15:0] == {COPY_IDENT, TRUNK_IDENT})
    else $error("segment list order wrong");
  chk_mode_code: assert property (tk && avs_read && avs_address == OFS_CAP_MODES
    |=> avs_readdata[31:2] == 30'h0 && avs_readdata[1:0] != 2'h0)
    else $error("supported modes code out of range");
  chk_report_gate: assert property ($rose(peer_report) |-> $past(rx_off_normal))
    else $error("peer report without trigger");
  chk_tx_mask: assert property (ce && cur_mode == MODE_REP
    |=> (cur_tx_seg_drive & $past(rx_source_seg)) == 2'h0)
    else $error("transmit on source segment while repeating");
  chk_load_only: assert property ($changed({cur_mode, cur_rate, cur_rx_seg})
    |-> $past(ld_r))
    else $error("operational state changed without init");
  cov_init: cover property (ld_r ##1 $changed(cur_mode));
  cov_report: cover property (peer_report);
  cov_refuse: cover property (!avs_waitrequest && avs_response == RESP_SLVERR);
endmodule : pmb_bank_chk
bind pmb_bank pmb_bank_chk i_chk (.clk(clk), .rst_n(rst_n), .ce(ce),
  .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
  .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
  .avs_response(avs_response), .avs_waitrequest(avs_waitrequest),
  .init_req(init_req), .rx_source_seg(rx_source_seg),
  .rx_off_normal(rx_off_normal), .cur_mode(cur_mode), .cur_rate(cur_rate),
  .cur_rx_seg(cur_rx_seg), .cur_tx_seg_drive(cur_tx_seg_drive),
  .peer_report(peer_report));
`default_nettype wire

// ===== bench/pmb_mgmt_master.sv
// management entity model: avalon-mm master, one access at a time
`timescale 1ns/1ps
`default_nettype none
module pmb_mgmt_master (
  input wire logic clk,
  output logic [pmb_pkg::AW-1:0] avs_address,
  output logic avs_read,
  output logic avs_write,
  output logic [31:0] avs_writedata,
  output logic [3:0] avs_byteenable,
  input wire logic [31:0] avs_readdata,
  input wire logic [1:0] avs_response,
  input wire logic avs_waitrequest,
  output logic timed_out
);
  import pmb_pkg::*;
  initial begin
    avs_address = '0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0;
    avs_byteenable = 4'hF;
    timed_out = 1'b0;
  end
  // one parameter per access, a group as successive accesses
  // callers send capability-consistent values except refusal cases
  task automatic acc(input logic wr, input logic [AW-1:0] a,
      input logic [31:0] d, output logic [31:0] rd, output logic [1:0] rsp);
    int n;
    n = 0;
    @(posedge clk);
    avs_address <= a;
    avs_read <= !wr;
    avs_write <= wr;
    avs_writedata <= d;
    do begin
      @(posedge clk);
      n++;
    end while (avs_waitrequest && n < 50);
    rd = avs_readdata;
    rsp = avs_response;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    // released data must not look valid
    avs_writedata <= ~d;
    if (avs_waitrequest) timed_out <= 1'b1;
  endtask : acc
endmodule : pmb_mgmt_master
`default_nettype wire

// ===== bench/test_phy_mgmt_parameter_bank.sv
// self-checking bench of the phy management parameter bank
`timescale 1ns/1ps
`default_nettype none
module test_phy_mgmt_parameter_bank;
  import pmb_pkg::*;
  typedef struct {
    logic wr;
    logic [AW-1:0] a;
    logic [31:0] d;
    logic [31:0] rd;
    logic [1:0] rsp;
  } pmb_row_t;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic ce = 1'b1;
  logic init_req = 1'b0;
  logic [1:0] rx_source_seg = 2'h1;
  logic rx_off_normal = 1'b0;
  logic [AW-1:0] avs_address;
  logic avs_read, avs_write, avs_waitrequest, peer_report, timed_out;
  logic [31:0] avs_writedata, avs_readdata, rd;
  logic [3:0] avs_byteenable, cur_rx_carrier, cur_tx_carrier;
  logic [1:0] avs_response, rsp, cur_mode, cur_rx_seg, cur_tx_seg_drive;
  logic [7:0] cur_rate;
  int errors = 0;
  int cmp_count = 0;
  pmb_row_t rows [19] = '{
    '{1'b0, OFS_LME_OPT, 32'h0, LME_OPT_NONE, RESP_OKAY},
    '{1'b0, OFS_CAP_MODES, 32'h0, 32'(CAP_MODES), RESP_OKAY},
    '{1'b0, OFS_CAP_SEGS, 32'h0, 32'({COPY_CAP, TRUNK_CAP, COPY_IDENT,
      TRUNK_IDENT}), RESP_OKAY},
    '{1'b0, OFS_CAP_TXC, 32'h0, 32'(CAP_TX_CARRIERS), RESP_OKAY},
    '{1'b0, OFS_CAP_RXC, 32'h0, 32'(CAP_RX_CARRIERS), RESP_OKAY},
    '{1'b1, OFS_CAP_RATES, 32'hFF, 32'h0, RESP_SLVERR},
    '{1'b0, OFS_CAP_RATES, 32'h0, CAP_RATES, RESP_OKAY},
    '{1'b1, OFS_OP_MODE, 32'(MODE_REP), 32'h0, RESP_SLVERR},
    '{1'b0, OFS_OP_MODE, 32'h0, 32'(RST_MODE), RESP_OKAY},
    '{1'b1, OFS_BT_MODE, 32'(MODE_REP), 32'h0, RESP_OKAY},
    '{1'b1, OFS_BT_MODE, 32'(MODE_BOTH), 32'h0, RESP_SLVERR},
    '{1'b0, OFS_BT_MODE, 32'h0, 32'(MODE_REP), RESP_OKAY},
    '{1'b1, OFS_BT_RATE, 32'(CAP_RATES[15:8]), 32'h0, RESP_OKAY},
    '{1'b1, OFS_BT_RATE, 32'h07, 32'h0, RESP_SLVERR},
    '{1'b1, OFS_BT_RXSEG, 32'h1, 32'h0, RESP_OKAY},
    '{1'b1, OFS_BT_RXC, 32'h5, 32'h0, RESP_OKAY},
    '{1'b1, OFS_BT_REP, 32'h1, 32'h0, RESP_OKAY},
    '{1'b0, OFS_STATUS, 32'h0, 32'h3, RESP_OKAY},
    '{1'b0, 7'h68, 32'h0, 32'h0, RESP_DECERR}};
  always #12.5 clk = ~clk;
  pmb_bank i_dut (.clk(clk), .rst_n(rst_n), .ce(ce),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_response(avs_response),
    .avs_waitrequest(avs_waitrequest), .init_req(init_req),
    .rx_source_seg(rx_source_seg), .rx_off_normal(rx_off_normal),
    .cur_mode(cur_mode), .cur_rate(cur_rate), .cur_rx_seg(cur_rx_seg),
    .cur_tx_seg_drive(cur_tx_seg_drive), .cur_rx_carrier(cur_rx_carrier),
    .cur_tx_carrier(cur_tx_carrier), .peer_report(peer_report));
  pmb_mgmt_master i_mgmt (.clk(clk), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_response(avs_response),
    .avs_waitrequest(avs_waitrequest), .timed_out(timed_out));
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      errors++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic test_done();
    $display("errors %0d compares %0d", errors, cmp_count);
    if (errors == 0 && cmp_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : test_done
  task automatic pulse_off(input logic exp);
    @(posedge clk);
    rx_off_normal <= 1'b1;
    @(posedge clk);
    rx_off_normal <= 1'b0;
    #1;
    chk(32'(peer_report), 32'(exp));
  endtask : pulse_off
  always @(posedge timed_out) begin
    errors++;
    test_done();
  end
  initial begin
    #200000;
    errors++;
    test_done();
  end
  initial begin
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    foreach (rows[i]) begin
      i_mgmt.acc(rows[i].wr, rows[i].a, rows[i].d, rd, rsp);
      chk(rd, rows[i].rd);
      chk(32'(rsp), 32'(rows[i].rsp));
    end
    @(posedge clk);
    init_req <= 1'b1;
    @(posedge clk);
    init_req <= 1'b0;
    repeat (3) @(posedge clk);
    #1;
    chk(32'({cur_mode, cur_rate, cur_rx_seg, cur_rx_carrier, cur_tx_carrier}),
      32'({MODE_REP, CAP_RATES[15:8], 2'h1, 4'h5, RST_CARRIER}));
    chk(32'(cur_tx_seg_drive), 32'h2);
    @(posedge clk);
    rx_source_seg <= 2'h2;
    repeat (2) @(posedge clk);
    #1;
    chk(32'(cur_tx_seg_drive), 32'h1);
    ce <= 1'b0;
    pulse_off(1'b0);
    ce <= 1'b1;
    pulse_off(1'b1);
    // report off, originating, load by register
    i_mgmt.acc(1'b1, OFS_BT_REP, 32'h0, rd, rsp);
    i_mgmt.acc(1'b1, OFS_BT_MODE, 32'(MODE_ORIG), rd, rsp);
    i_mgmt.acc(1'b1, OFS_CTRL, 32'h1, rd, rsp);
    repeat (4) @(posedge clk);
    #1;
    chk(32'({cur_mode, cur_tx_seg_drive}), 32'({MODE_ORIG, 2'h3}));
    pulse_off(1'b0);
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    #1;
    chk(32'({cur_mode, cur_rate, peer_report, avs_waitrequest}),
      32'({RST_MODE, RST_RATE, 1'b0, 1'b1}));
    @(posedge clk);
    rst_n <= 1'b1;
    i_mgmt.acc(1'b0, OFS_BT_RATE, 32'h0, rd, rsp);
    chk(rd, 32'(RST_RATE));
    test_done();
  end
endmodule : test_phy_mgmt_parameter_bank
`default_nettype wire
